// [hdl/dsps_pad.sv]
`timescale 1ns/1ps
module dsps_pad (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Pad control
  dsps_pad_if.pad  bus
);

  // Output stage; a selected peripheral overrides the port latch and direction
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bus.pin_o  <= 1'h0;
      bus.pin_oe <= 1'h0;
    end else if (bus.sel) begin
      bus.pin_o  <= bus.fn_out;
      bus.pin_oe <= bus.fn_oe;
    end else begin
      bus.pin_o  <= bus.port_data;
      bus.pin_oe <= bus.port_dir;
    end
  end

endmodule // dsps_pad

// [hdl/dsps_pad_if.sv]
`timescale 1ns/1ps
interface dsps_pad_if;
  logic sel;        // Peripheral function owns the pin
  logic fn_out;     // Peripheral output level
  logic fn_oe;      // Peripheral drives the pin
  logic port_data;  // Port output latch
  logic port_dir;   // Port direction, high drives
  logic pin_o;      // Registered pin level
  logic pin_oe;     // Registered pin enable

  modport pad (
    input  sel,
    input  fn_out,
    input  fn_oe,
    input  port_data,
    input  port_dir,
    output pin_o,
    output pin_oe
  );

  modport ctl (
    output sel,
    output fn_out,
    output fn_oe,
    output port_data,
    output port_dir,
    input  pin_o,
    input  pin_oe
  );
endinterface

// [hdl/dsps_pkg.sv]
package dsps_pkg;

  // ***************************************************************
  // Pad map
  // ***************************************************************
  localparam int PAD_COUNT = 6;
  localparam int PAD_SERIAL_UNIT_CLOCK_PIN = 0;  // Shared with port_g_bit_clock_shared
  localparam int PAD_ACK_CH_A = 1;               // dma_ack_out_ch_a / port_b_bit_ack_shared
  localparam int PAD_ACK_CH_C = 2;               // dma_ack_out_ch_c / port_c_bit_ack_shared
  localparam int PAD_END_STOP_CH_C = 3;          // port_c_bit_end_stop_shared
  localparam int PAD_REQUEST_CH_A = 4;           // dma_request_in_ch_a / port_b_bit_request_shared
  localparam int PAD_REQUEST_CH_C = 5;           // dma_request_in_ch_c / port_c_bit_request_shared

  // ***************************************************************
  // Channel slots on the vector ports toward the DMA controller
  // ***************************************************************
  localparam int CH_A = 0;
  localparam int CH_C = 1;
  localparam int CH_COUNT = 2;

  // ***************************************************************
  // Mode pins and settling
  // ***************************************************************
  localparam int MODE_W = 3;
  localparam int SETTLE_W = 2;
  localparam logic [SETTLE_W-1:0] MODE_SETTLE = 2'h2;  // Edges for the two-stage synchroniser to fill
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

endpackage

// [hdl/dsps_top.sv]
//
// Contract
// - Serial clock on pin in external or output mode
// - Port owns clock pin only when both off
// - Ack output drives pin when enabled, else port
// - End output drives pin when enabled
// - Stop input taken from pin when enabled
// - End/stop pin to port only when both off
// - Request pin feeds DMA; port direction still drives pin
// - Mode pins sampled to fix operating mode
`timescale 1ns/1ps
module dsps_top (
  // Clock and reset
  input  wire logic                              CLK,
  input  wire logic                              RST,
  // Shared pins, split into level, output and enable
  input  wire logic [dsps_pkg::PAD_COUNT-1:0]    PIN_IN,
  output logic      [dsps_pkg::PAD_COUNT-1:0]    PIN_OUT,
  output logic      [dsps_pkg::PAD_COUNT-1:0]    PIN_OE,
  // Port latches and pin readback
  input  wire logic [dsps_pkg::PAD_COUNT-1:0]    PORT_DATA,
  input  wire logic [dsps_pkg::PAD_COUNT-1:0]    PORT_DIR,
  output logic      [dsps_pkg::PAD_COUNT-1:0]    PORT_IN,
  // Serial unit
  input  wire logic                              SER_EXT_CLK_MODE,
  input  wire logic                              SER_CLK_OUT_EN,
  input  wire logic                              SER_CLK_OUT,
  output logic                                   SER_CLK_IN,
  // DMA acknowledge, channels A and C
  input  wire logic [dsps_pkg::CH_COUNT-1:0]     DMA_ACK_EN,
  input  wire logic [dsps_pkg::CH_COUNT-1:0]     DMA_ACK,
  // DMA end and stop, channel C
  input  wire logic                              DMA_END_EN,
  input  wire logic                              DMA_END,
  input  wire logic                              DMA_STOP_EN,
  output logic                                   DMA_STOP_IN,
  // DMA requests, channels A and C
  input  wire logic [dsps_pkg::CH_COUNT-1:0]     DMA_REQ_SEL,
  output logic      [dsps_pkg::CH_COUNT-1:0]     DMA_REQ_IN,
  // Operating mode
  input  wire logic [dsps_pkg::MODE_W-1:0]       MODE_PINS,
  output logic      [dsps_pkg::MODE_W-1:0]       MODE,
  output logic                                   MODE_VALID
);

  localparam int SCK = dsps_pkg::PAD_SERIAL_UNIT_CLOCK_PIN;
  localparam int AKA = dsps_pkg::PAD_ACK_CH_A;
  localparam int AKC = dsps_pkg::PAD_ACK_CH_C;
  localparam int EST = dsps_pkg::PAD_END_STOP_CH_C;
  localparam int RQA = dsps_pkg::PAD_REQUEST_CH_A;
  localparam int RQC = dsps_pkg::PAD_REQUEST_CH_C;

  logic [dsps_pkg::PAD_COUNT-1:0] pin_s1;
  logic [dsps_pkg::PAD_COUNT-1:0] pin_s2;
  logic [dsps_pkg::MODE_W-1:0]    mode_s1;
  logic [dsps_pkg::MODE_W-1:0]    mode_s2;
  logic [dsps_pkg::SETTLE_W-1:0]  settle;
  logic [dsps_pkg::PAD_COUNT-1:0] sel;
  logic [dsps_pkg::PAD_COUNT-1:0] fn_out;
  logic [dsps_pkg::PAD_COUNT-1:0] fn_oe;

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************

  // Pins are asynchronous to CLK; only the second stage is read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= PIN_IN;
      pin_s2 <= pin_s1;
    end
  end

  assign PORT_IN = pin_s2;  // Port readback sees the pad level in every mode

  // ***************************************************************
  // Function selection per pad
  // ***************************************************************

  // Request pads are never claimed, so only the port direction can drive them
  always_comb begin
    sel    = '0;
    fn_out = '0;
    fn_oe  = '0;
    sel[SCK]    = SER_EXT_CLK_MODE | SER_CLK_OUT_EN;
    fn_out[SCK] = SER_CLK_OUT;
    fn_oe[SCK]  = SER_CLK_OUT_EN;
    sel[AKA]    = DMA_ACK_EN[dsps_pkg::CH_A];
    fn_out[AKA] = DMA_ACK[dsps_pkg::CH_A];
    fn_oe[AKA]  = 1'h1;
    sel[AKC]    = DMA_ACK_EN[dsps_pkg::CH_C];
    fn_out[AKC] = DMA_ACK[dsps_pkg::CH_C];
    fn_oe[AKC]  = 1'h1;
    sel[EST]    = DMA_END_EN | DMA_STOP_EN;
    fn_out[EST] = DMA_END;
    fn_oe[EST]  = DMA_END_EN;
    sel[RQA]    = 1'h0;
    sel[RQC]    = 1'h0;
  end

  // ***************************************************************
  // Pad cells
  // ***************************************************************

  dsps_pad_if pif [dsps_pkg::PAD_COUNT] ();

  genvar gi;
  generate
    for (gi = 0; gi < dsps_pkg::PAD_COUNT; gi++) begin : g_pad
      assign pif[gi].sel       = sel[gi];
      assign pif[gi].fn_out    = fn_out[gi];
      assign pif[gi].fn_oe     = fn_oe[gi];
      assign pif[gi].port_data = PORT_DATA[gi];
      assign pif[gi].port_dir  = PORT_DIR[gi];
      assign PIN_OUT[gi]       = pif[gi].pin_o;
      assign PIN_OE[gi]        = pif[gi].pin_oe;
      dsps_pad u_pad (
        .CLK (CLK),
        .RST (RST),
        .bus (pif[gi].pad)
      );
    end
  endgenerate

  // ***************************************************************
  // Inputs toward the peripherals
  // ***************************************************************

  // Serial clock in from the pad only in external shift clock mode
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SER_CLK_IN <= 1'h0;
    end else begin
      SER_CLK_IN <= SER_EXT_CLK_MODE & pin_s2[SCK];
    end
  end

  // Stop input is forced low while disabled so a floating pad cannot halt a channel
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DMA_STOP_IN <= 1'h0;
    end else begin
      DMA_STOP_IN <= DMA_STOP_EN & pin_s2[EST];
    end
  end

  // Requests pass to the start logic only when selected as a start source
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DMA_REQ_IN <= '0;
    end else begin
      DMA_REQ_IN <= DMA_REQ_SEL & {pin_s2[RQC], pin_s2[RQA]};
    end
  end

  // ***************************************************************
  // Operating mode capture
  // ***************************************************************

  // Mode pins synchronised like any pin
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_s1 <= dsps_pkg::MODE_RESET;
      mode_s2 <= dsps_pkg::MODE_RESET;
    end else begin
      mode_s1 <= MODE_PINS;
      mode_s2 <= mode_s1;
    end
  end

  // Latched once after release; later pin motion is ignored since the pins are straps
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      settle     <= '0;
      MODE       <= dsps_pkg::MODE_RESET;
      MODE_VALID <= 1'h0;
    end else if (!MODE_VALID) begin
      if (settle == dsps_pkg::MODE_SETTLE) begin
        MODE       <= mode_s2;
        MODE_VALID <= 1'h1;
      end else begin
        settle <= settle + 2'h1;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_sck_out_drive: assert property (SER_CLK_OUT_EN |=> PIN_OE[SCK] && PIN_OUT[SCK] == $past(SER_CLK_OUT))
    else $error("serial clock output not driven on its pin");
  a_sck_ext_in: assert property (SER_EXT_CLK_MODE && !SER_CLK_OUT_EN |=> !PIN_OE[SCK]
    && SER_CLK_IN == $past(pin_s2[SCK])) else $error("external serial clock not routed");
  a_sck_port_use: assert property (!SER_EXT_CLK_MODE && !SER_CLK_OUT_EN |=> PIN_OE[SCK] == $past(PORT_DIR[SCK])
    && PIN_OUT[SCK] == $past(PORT_DATA[SCK])) else $error("clock pin not handed to port");
  a_ack_drive: assert property (DMA_ACK_EN[dsps_pkg::CH_C] |=> PIN_OE[AKC]
    && PIN_OUT[AKC] == $past(DMA_ACK[dsps_pkg::CH_C])) else $error("acknowledge not driven");
  a_ack_port: assert property (!DMA_ACK_EN[dsps_pkg::CH_A] |=> PIN_OE[AKA] == $past(PORT_DIR[AKA])
    && PIN_OUT[AKA] == $past(PORT_DATA[AKA])) else $error("acknowledge pin not handed to port");
  a_end_drive: assert property (DMA_END_EN |=> PIN_OE[EST] && PIN_OUT[EST] == $past(DMA_END))
    else $error("end output not driven");
  a_stop_route: assert property (DMA_STOP_EN && !DMA_END_EN |=> !PIN_OE[EST]
    && DMA_STOP_IN == $past(pin_s2[EST])) else $error("stop input not routed");
  a_end_stop_port: assert property (!DMA_END_EN && !DMA_STOP_EN |=> PIN_OE[EST] == $past(PORT_DIR[EST])
    && !DMA_STOP_IN) else $error("end/stop pin not handed to port");
  a_req_feed: assert property (DMA_REQ_IN[dsps_pkg::CH_A] == ($past(DMA_REQ_SEL[dsps_pkg::CH_A])
    && $past(pin_s2[RQA]))) else $error("request not fed from selected source");
  a_req_drv_off: assert property (!PORT_DIR[RQC] |=> !PIN_OE[RQC])
    else $error("request pin driven without port direction");
  a_mode_capture: assert property ($rose(MODE_VALID) |-> MODE == $past(mode_s2) ##1 MODE_VALID [*3])
    else $error("mode not captured or not held");
  a_mode_stable: assert property (MODE_VALID |=> $stable(MODE))
    else $error("mode changed after capture");

endmodule // dsps_top

// [testbench/dsps_pin_model.sv]
`timescale 1ns/1ps
// ***********************************************
// Board side of the six shared pads
// ***********************************************
module dsps_pin_model (
  // Clock
  input  wire logic       clk,
  // Block side of the pads
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  // External drivers on the board
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_oe,
  // Resolved pad level
  output logic      [5:0] pin_lvl
);
  logic [5:0] last;

  // Remember the level so a floating pad can drift away from it
  always_ff @(posedge clk) begin
    last <= pin_lvl;
  end

  // Block drive wins; an undriven pad shows the inverse so stale data never reads as good
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe & ~last);
endmodule // dsps_pin_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  // ***********************************************
  // Signals
  // ***********************************************
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic [5:0] pin_in, pin_out, pin_oe, port_data, port_dir, port_in, ext_val, ext_oe;
  logic       ext_mode, ce, ser_clk_out, ser_clk_in, en, dma_end, st, stop_in, mode_valid;
  logic [1:0] ack_en, ack, req_sel, req_in;
  logic [2:0] mode_pins, mode;
  int         bad_count = 0;
  int         tests_run = 0;

  // Clock at 20 MHz
  always #25 clk = ~clk;

  dsps_top dut_u (.CLK(clk), .RST(rst), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PORT_DATA(port_data), .PORT_DIR(port_dir), .PORT_IN(port_in), .SER_EXT_CLK_MODE(ext_mode),
    .SER_CLK_OUT_EN(ce), .SER_CLK_OUT(ser_clk_out), .SER_CLK_IN(ser_clk_in), .DMA_ACK_EN(ack_en),
    .DMA_ACK(ack), .DMA_END_EN(en), .DMA_END(dma_end), .DMA_STOP_EN(st), .DMA_STOP_IN(stop_in),
    .DMA_REQ_SEL(req_sel), .DMA_REQ_IN(req_in), .MODE_PINS(mode_pins), .MODE(mode), .MODE_VALID(mode_valid));

  dsps_pin_model pins_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_oe(ext_oe),
    .pin_lvl(pin_in));

  // ***********************************************
  // Helpers
  // ***********************************************
  // Pin inputs need three edges through sync and gate, so four is always enough
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("Counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ***********************************************
  // Scenarios
  // ***********************************************
  // Serial clock pad in all four enable combinations, clock and board level both ways
  task automatic t_serial;
    for (int i = 0; i < 8; i++) begin
      ext_mode = i[0];
      ce = i[1];
      ser_clk_out = i[2];
      ext_val[0] = i[2];
      settle;
      chk({pin_oe[0], ser_clk_in}, {ce | ~ext_mode, ext_mode & i[2]});
      if (ce | ~ext_mode) chk(pin_out[0], ce ? i[2] : 1'h1);
    end
    {ext_mode, ce, ser_clk_out} = 3'h0;
    ext_val[0] = 1'h1;
    $display("done serial");
  endtask

  // Both ack pads, channels opposite, port direction input so claiming shows on the enable
  task automatic t_ack;
    port_dir = 6'h0;
    port_data = 6'h0;
    for (int i = 0; i < 4; i++) begin
      ack_en = {~i[0], i[0]};
      ack = {2{i[1]}};
      settle;
      chk({pin_oe[2:1], pin_out[2:1]}, {ack_en, ack_en[1] ? i[1] : 1'h0, ack_en[0] ? i[1] : 1'h0});
    end
    ack_en = 2'h0;
    port_dir = 6'h3F;
    port_data = 6'h3F;
    $display("done ack");
  endtask

  // End output and stop input sharing one pad
  task automatic t_endstop;
    for (int i = 0; i < 8; i++) begin
      en = i[0];
      st = i[1];
      dma_end = i[2];
      ext_val[3] = i[2];
      settle;
      chk({pin_oe[3], stop_in}, {en | ~st, st & i[2]});
      if (en | ~st) chk(pin_out[3], en ? i[2] : 1'h1);
    end
    {en, st, dma_end} = 3'h0;
    ext_val[3] = 1'h1;
    $display("done endstop");
  endtask

  // Request pads: every select against every level, port driver off
  task automatic t_req;
    port_dir = 6'h0F;
    for (int i = 0; i < 16; i++) begin
      req_sel = i[1:0];
      ext_val[5:4] = i[3:2];
      settle;
      chk({pin_oe[5:4], port_in[5:4], req_in}, {2'h0, i[3:2], i[1:0] & i[3:2]});
    end
    port_dir = 6'h3F;
    settle;
    chk(pin_oe[5:4], 2'h3);
    req_sel = 2'h0;
    ext_val = 6'h3F;
    $display("done request");
  endtask

  // Mode straps: captured once, ignored later, recaptured after a second reset
  task automatic t_mode;
    chk({mode_valid, mode}, 4'hD);
    mode_pins = 3'h2;
    settle;
    chk({mode_valid, mode}, 4'hD);
    rst = 1'h1;
    @(posedge clk);
    #1;
    chk({mode_valid, mode, pin_oe}, 10'h0);
    rst = 1'h0;
    settle;
    chk({mode_valid, mode}, 4'hA);
    $display("done mode");
  endtask

  // ***********************************************
  // Main sequence and watchdog
  // ***********************************************
  initial begin
    {ext_mode, ce, ser_clk_out, en, dma_end, st} = 6'h0;
    {ack_en, ack, req_sel} = 6'h0;
    port_data = 6'h3F;
    port_dir = 6'h3F;
    ext_val = 6'h3F;
    ext_oe = 6'h3F;
    mode_pins = 3'h5;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'h0;
    settle;
    t_mode;
    t_serial;
    t_ack;
    t_endstop;
    t_req;
    stop_test;
  end

  // Scenarios need about 200 cycles; allow ten times that
  initial begin
    #100000;
    bad_count++;
    $display("Watchdog expired");
    stop_test;
  end
endmodule // tb_top
